//--- bench/buffer_program_load_sequencer_tb.sv
// Self-checking bench for the buffered program load sequencer.
`timescale 1ns/1ns
module buffer_program_load_sequencer_tb;
    import bpl_pkg::*;
    logic              i_ref_clk = 1'b0;
    logic              i_resetn  = 1'b0;
    logic              susp      = 1'b0;
    logic              done      = 1'b0;
    logic [10:0]       count_hi  = 11'h000;
    logic              wr_valid;
    bus_write_type     wr;
    seq_state_type     state;
    logic              ready, busy, start, error, fail, ctx;
    logic [IDX_W-1:0]  count;
    buf_write_type     bw;
    int                fail_count = 0;
    int                checks     = 0;
    int                tn         = 0;

    always #2 i_ref_clk = ~i_ref_clk;

    flash_host_model h (.i_ref_clk(i_ref_clk), .o_wr_valid(wr_valid),
        .o_wr(wr));
    buffer_program_load_sequencer dut_u (.i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn), .i_wr_valid(wr_valid), .i_wr(wr),
        .i_erase_suspended(susp), .i_prog_done(done), .o_state(state),
        .o_ready(ready), .o_busy(busy), .o_start(start), .o_error(error),
        .o_fail(fail), .o_erase_suspend_ctx(ctx), .o_count(count),
        .o_buf(bw));

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d.", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Runs one whole sequence; bad is the index of a word outside the page.
    task automatic run_seq(input logic [ADDR_W-1:0] a0,
        input logic [IDX_W-1:0] n, input int bad, input logic [7:0] cf);
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [IDX_W-1:0]  k;
        logic              bf, ok, s0;
        bf = (count_hi != 11'h000);
        s0 = susp;
        h.send(a0, 16'h0070);
        chk("state", state, ST_READY);
        h.send(a0, {8'h00, CMD_BUF_PROG});
        chk("error", error, 1'b0);
        h.send(a0, {count_hi, n});
        susp = ~s0;
        chk("count", count, n);
        chk("state", state, n == 0 ? ST_CONFIRM : ST_LOAD2);
        for (int i = 0; i < n; i++) begin
            k = i[IDX_W-1:0];
            d = 16'($urandom);
            a = {a0[ADDR_W-1:PAGE_LSB], 5'($urandom)};
            if (i == bad) a = a0 ^ 24'h000020;
            bf |= (i == bad);
            h.send(a, d);
            chk("buf", bw, {1'b1, k, a, d});
        end
        chk("state", state, ST_CONFIRM);
        chk("ctx", ctx, s0);
        h.send(a0, {8'h00, cf});
        ok = (cf == CMD_CONFIRM) && !bf;
        chk("fail", fail, bf);
        chk("start", start, ok);
        chk("error", error, !ok);
        chk("state", state, ok ? ST_BUSY : ST_READY);
        chk("ctx", ctx, s0);
        susp = s0;
        h.idle();
        if (ok) begin
            h.send(a0, {8'h00, CMD_BUF_PROG});
            h.idle();
            chk("busy", busy, 1'b1);
            done = 1'b1;
            @(negedge i_ref_clk);
            done = 1'b0;
            chk("ready", ready, 1'b1);
        end
        tn++;
        $display("Test %0d done.", tn);
    endtask

    initial begin
        int n, bad;
        logic [7:0] cf;
        void'($urandom(3));
        repeat (2) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        @(negedge i_ref_clk);
        run_seq(24'h012340, 5'h02, -1, CMD_CONFIRM);
        run_seq(24'h0ABC00, 5'h00, -1, CMD_CONFIRM);
        run_seq(24'hFFFFE0, 5'h1F, -1, CMD_CONFIRM);
        run_seq(24'h000100, 5'h03, 1, CMD_CONFIRM);
        run_seq(24'h000100, 5'h01, 0, CMD_CONFIRM);
        run_seq(24'h000200, 5'h02, -1, 8'hFF);
        count_hi = 11'h001;
        run_seq(24'h000300, 5'h02, -1, CMD_CONFIRM);
        count_hi = 11'h000;
        susp = 1'b1;
        run_seq(24'h004000, 5'h04, -1, CMD_CONFIRM);
        for (int t = 0; t < 12; t++) begin
            n   = $urandom % 32;
            bad = (n > 0 && $urandom % 3 == 0) ? int'($urandom % n) : -1;
            cf  = ($urandom % 3 == 0) ? 8'($urandom) : CMD_CONFIRM;
            susp = 1'($urandom);
            run_seq(24'($urandom), 5'(n), bad, cf);
        end
        give_verdict();
    end

    initial begin
        #40000;
        fail_count++;
        give_verdict();
    end
endmodule // buffer_program_load_sequencer_tb

//--- bench/flash_host_model.sv
// Host side model that issues bus writes to the load sequencer.
`timescale 1ns/1ns
module flash_host_model
    import bpl_pkg::*;
(
    input  wire logic             i_ref_clk,
    output logic                  o_wr_valid,
    output bpl_pkg::bus_write_type o_wr
);
    initial begin
        o_wr_valid = 1'b0;
        o_wr       = '0;
    end
    // Drives one write at a falling edge and holds it over the taking edge.
    task automatic send(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        o_wr_valid = 1'b1;
        o_wr       = {a, d};
        @(negedge i_ref_clk);
    endtask
    // Releases the bus; the lines show the inverse of the last value.
    task automatic idle();
        o_wr_valid = 1'b0;
        o_wr       = ~o_wr;
        @(negedge i_ref_clk);
    endtask
endmodule // flash_host_model

//--- logic/bpl_pkg.sv
// Shared constants, types and decode helpers for the buffer load sequencer.
package bpl_pkg;

    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int IDX_W    = 5;
    localparam int PAGE_LSB = IDX_W;
    localparam int CMD_W    = 8;

    localparam logic [CMD_W-1:0]  CMD_BUF_PROG = 8'hE8;
    localparam logic [CMD_W-1:0]  CMD_CONFIRM  = 8'hD0;
    localparam logic [IDX_W-1:0]  IDX_RST      = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST     = 16'h0000;

    typedef enum logic [2:0] {
        ST_READY,
        ST_LOAD1,
        ST_LOAD2,
        ST_CONFIRM,
        ST_BUSY
    } seq_state_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_write_type;

    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  index;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } buf_write_type;

    // Returns the buffer page that a word address falls in.
    function automatic logic [ADDR_W-PAGE_LSB-1:0] page_of(
        input logic [ADDR_W-1:0] addr);
        page_of = addr[ADDR_W-1:PAGE_LSB];
    endfunction

endpackage

//--- logic/buffer_program_load_sequencer.sv
// Buffered program loading sequence of the flash command interface.
`timescale 1ns/1ns
// Operation
// RQ1: First write after setup stores word count.
// RQ2: Zero count skips loading, goes to confirm.
// RQ3: Nonzero count loads one word per write.
// RQ4: After counted words, wait in confirm state.
// RQ5: Address outside start page fails the operation.
// RQ6: Confirm code starts busy, else error ready.
// RQ7: Same sequence keeps erase suspend context.
module buffer_program_load_sequencer
    import bpl_pkg::*;
(
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_resetn,
    input  wire logic                        i_wr_valid,
    input  wire bpl_pkg::bus_write_type      i_wr,
    input  wire logic                        i_erase_suspended,
    input  wire logic                        i_prog_done,
    output bpl_pkg::seq_state_type           o_state,
    output logic                             o_ready,
    output logic                             o_busy,
    output logic                             o_start,
    output logic                             o_error,
    output logic                             o_fail,
    output logic                             o_erase_suspend_ctx,
    output logic [bpl_pkg::IDX_W-1:0]        o_count,
    output bpl_pkg::buf_write_type           o_buf
);

    seq_state_type     state_q;
    seq_state_type     state_d;
    logic [IDX_W-1:0]  count_q;
    logic [IDX_W-1:0]  idx_q;
    logic [ADDR_W-1:0] start_addr_q;
    logic              fail_q;
    logic              error_q;
    logic              ctx_q;
    logic              start_q;
    buf_write_type     buf_q;
    logic              addr_match;
    logic [CMD_W-1:0]  cmd;
    logic              count_zero;
    logic              count_ovf;
    logic              last_word;

    same_page_check u_page (
        .i_start_addr (start_addr_q),
        .i_addr       (i_wr.addr),
        .o_match      (addr_match)
    );

    always_comb begin
        cmd        = i_wr.data[CMD_W-1:0];
        count_zero = (i_wr.data == DATA_RST);
        count_ovf  = (i_wr.data[DATA_W-1:IDX_W] != '0);
        last_word  = ((idx_q + 5'h01) == count_q);
    end

    // Next state of the loading sequence.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_READY: begin
                if (i_wr_valid && cmd == CMD_BUF_PROG) begin
                    state_d = ST_LOAD1;
                end
            end
            ST_LOAD1: begin
                if (i_wr_valid && count_zero) begin
                    state_d = ST_CONFIRM; // RQ2
                end else if (i_wr_valid) begin
                    state_d = ST_LOAD2; // RQ3
                end
            end
            ST_LOAD2: begin
                if (i_wr_valid && last_word) begin
                    state_d = ST_CONFIRM; // RQ4
                end
            end
            ST_CONFIRM: begin
                if (i_wr_valid && cmd == CMD_CONFIRM && !fail_q) begin
                    state_d = ST_BUSY; // RQ6
                end else if (i_wr_valid) begin
                    state_d = ST_READY; // RQ6
                end
            end
            ST_BUSY: begin
                if (i_prog_done) begin
                    state_d = ST_READY;
                end
            end
            default: begin
                state_d = ST_READY;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_READY;
        end else begin
            state_q <= state_d;
        end
    end

    // Word count and start address are caught from the count write.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_q      <= IDX_RST;
            start_addr_q <= ADDR_RST;
        end else if (state_q == ST_LOAD1 && i_wr_valid) begin
            count_q      <= i_wr.data[IDX_W-1:0]; // RQ1
            start_addr_q <= i_wr.addr; // RQ1
        end
    end

    // Index of the next buffer slot to be loaded.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            idx_q <= IDX_RST;
        end else if (state_q == ST_LOAD1) begin
            idx_q <= IDX_RST;
        end else if (state_q == ST_LOAD2 && i_wr_valid) begin
            idx_q <= idx_q + 5'h01; // RQ3
        end
    end

    // Each data write is passed to the program buffer for one cycle.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            buf_q <= '0;
        end else begin
            buf_q.valid <= (state_q == ST_LOAD2) && i_wr_valid; // RQ3
            buf_q.index <= idx_q;
            buf_q.addr  <= i_wr.addr;
            buf_q.data  <= i_wr.data;
        end
    end

    // Failure is armed by a bad count or an address outside the page.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fail_q <= 1'b0;
        end else if (state_q == ST_READY && state_d == ST_LOAD1) begin
            fail_q <= 1'b0;
        end else if (state_q == ST_LOAD1 && i_wr_valid && count_ovf) begin
            fail_q <= 1'b1;
        end else if (state_q == ST_LOAD2 && i_wr_valid && !addr_match) begin
            fail_q <= 1'b1; // RQ5
        end
    end

    // Error stays until the next buffered program setup.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            error_q <= 1'b0;
        end else if (state_q == ST_CONFIRM && state_d == ST_READY) begin
            error_q <= 1'b1; // RQ6
        end else if (state_q == ST_READY && state_d == ST_LOAD1) begin
            error_q <= 1'b0;
        end
    end

    // Erase suspend context is caught at setup and held to the end.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctx_q <= 1'b0;
        end else if (state_q == ST_READY) begin
            ctx_q <= i_erase_suspended; // RQ7
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= (state_q == ST_CONFIRM) && (state_d == ST_BUSY);
        end
    end

    always_comb begin
        o_state             = state_q;
        o_ready             = (state_q == ST_READY);
        o_busy              = (state_q == ST_BUSY);
        o_start             = start_q;
        o_error             = error_q;
        o_fail              = fail_q;
        o_erase_suspend_ctx = ctx_q;
        o_count             = count_q;
        o_buf               = buf_q;
    end

    count_store_a: assert property ( // RQ1
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_LOAD1 && i_wr_valid)
        |=> (count_q == $past(i_wr.data[IDX_W-1:0]))
            && (start_addr_q == $past(i_wr.addr)))
        else $error("Word count not stored.");

    zero_skip_a: assert property ( // RQ2
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_LOAD1 && i_wr_valid && i_wr.data == DATA_RST)
        |=> state_q == ST_CONFIRM ##1 !buf_q.valid)
        else $error("Zero count did not skip loading.");

    data_load_a: assert property ( // RQ3
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_LOAD2 && i_wr_valid)
        |=> buf_q.valid && buf_q.data == $past(i_wr.data)
            && buf_q.index == $past(idx_q))
        else $error("Data word not loaded.");

    load_enter_a: assert property ( // RQ3
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_LOAD1 && i_wr_valid && i_wr.data != DATA_RST)
        |=> state_q == ST_LOAD2 && idx_q == IDX_RST)
        else $error("Nonzero count did not enter loading.");

    load_done_a: assert property ( // RQ4
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_LOAD2 && i_wr_valid)
        |=> (state_q == ST_CONFIRM) == ($past(idx_q) + 5'h01 == count_q))
        else $error("Load end not at counted word.");

    addr_fail_a: assert property ( // RQ5
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_LOAD2 && i_wr_valid
         && page_of(i_wr.addr) != page_of(start_addr_q))
        |=> fail_q [*1] ##0 (state_q != ST_BUSY))
        else $error("Bad address did not fail the operation.");

    confirm_go_a: assert property ( // RQ6
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == ST_CONFIRM && i_wr_valid)
        |=> (state_q == ST_BUSY && start_q)
            || (state_q == ST_READY && error_q))
        else $error("Confirm step gave wrong outcome.");

    ctx_hold_a: assert property ( // RQ7
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q != ST_READY && $past(state_q) != ST_READY)
        |-> $stable(ctx_q))
        else $error("Erase suspend context changed mid sequence.");

endmodule // buffer_program_load_sequencer

//--- logic/same_page_check.sv
// Checks that a loaded word address lies in the start address buffer page.
`timescale 1ns/1ns
module same_page_check
    import bpl_pkg::*;
(
    input  wire logic [bpl_pkg::ADDR_W-1:0] i_start_addr,
    input  wire logic [bpl_pkg::ADDR_W-1:0] i_addr,
    output logic                            o_match
);

    always_comb begin
        o_match = (page_of(i_addr) == page_of(i_start_addr));
    end

endmodule // same_page_check
